// ---- hw/padc_top.sv ----
// Summary of operation
// R1 - Every pin of the first three ports can serve an analog, digital or external-interrupt function by configuration.
// R2 - Software puts analog-function pins in analog mode and digital or interrupt pins in digital mode.
// R3 - Software sets the skip bit of each pin used by an analog function so it stays reserved.
// R4 - The crossbar never places a peripheral signal on a pin whose skip bit is set.
// R5 - Enabled peripheral signals are placed in fixed priority: UART, SPI, SMBus, comparator, sysclk, capture/compare, counter clock, timers.
// R6 - Each enabled signal in priority order gets the lowest-numbered pin that is neither skipped nor taken.
// R7 - Special function signals are not placed by the crossbar and software must skip their pins.
// R8 - The SPI slave select gets a pin only while the SPI runs in four-wire mode.
// R9 - Each input-mode bit controls the pin of the same index.
// R10 - An input-mode bit of 0 makes the pin analog and 1 keeps it digital.
// R11 - An analog pin has its weak pull-up, digital driver and digital receiver disabled.
// R12 - An output-mode bit of 0 makes the pin open-drain and 1 makes it push-pull.
// R13 - The output-mode bit is ignored while the pin is in analog mode.
// R14 - The upper two bits of the sixth-pin port mode registers read zero and ignore writes.
`timescale 1ns/100ps
module padc_top
  import padc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [XBAR_PINS-1:0] port012_analog_select,
  input wire logic [XBAR_PINS-1:0] port012_output_drive_select,
  input wire logic [XBAR_PINS-1:0] port_pin_skip_bits,
  input wire logic [N_SIG-1:0] periph_enable,
  input wire logic spi_four_wire,
  input wire logic [N_SIG-1:0] periph_out,
  input wire logic [XBAR_PINS-1:0] port012_latch,
  input wire logic [P3_PINS-1:0] port3_latch,
  input wire logic [P6_PINS-1:0] port6_latch,
  input wire logic [ALL_PINS-1:0] pin_in,
  output logic [ALL_PINS-1:0] pin_out,
  output logic [ALL_PINS-1:0] pin_oe,
  output logic [ALL_PINS-1:0] pin_pullup_en,
  output logic [ALL_PINS-1:0] pin_receiver_en,
  output logic [ALL_PINS-1:0] pin_analog_en,
  output logic [ALL_PINS-1:0] pin_value,
  output logic [XBAR_PINS-1:0][SIG_CODE_W-1:0] pin_assign,
  output logic [N_SIG-1:0] periph_placed,
  output logic [N_SIG-1:0] periph_in
);
  // Configuration registers
  logic [7:0] p3_analog_ff, nxt_p3_analog;
  logic [7:0] p3_drive_ff, nxt_p3_drive;
  logic [7:0] p6_analog_ff, nxt_p6_analog;
  logic [7:0] p6_drive_ff, nxt_p6_drive;
  logic [7:0] rdata_ff, nxt_rdata;
  logic page_hit;

  // Mode registers answer on the configuration page only
  assign page_hit = (sfr_page == SFR_PAGE_CFG);

  always_comb begin
    nxt_p3_analog = p3_analog_ff;
    nxt_p3_drive = p3_drive_ff;
    nxt_p6_analog = p6_analog_ff;
    nxt_p6_drive = p6_drive_ff;
    if (sfr_wr_en && page_hit) begin
      if (sfr_addr == P3_ANALOG_SEL_ADDR) begin
        nxt_p3_analog = sfr_wdata;
      end else if (sfr_addr == P3_OUT_DRIVE_ADDR) begin
        nxt_p3_drive = sfr_wdata;
      end else if (sfr_addr == P6_ANALOG_SEL_ADDR) begin
        nxt_p6_analog = sfr_wdata & P6_IMPL_MASK; // R14
      end else if (sfr_addr == P6_OUT_DRIVE_ADDR) begin
        nxt_p6_drive = sfr_wdata & P6_IMPL_MASK; // R14
      end
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd_en) begin
      if (!page_hit) begin
        nxt_rdata = SFR_READ_IDLE;
      end else if (sfr_addr == P3_ANALOG_SEL_ADDR) begin
        nxt_rdata = p3_analog_ff;
      end else if (sfr_addr == P3_OUT_DRIVE_ADDR) begin
        nxt_rdata = p3_drive_ff;
      end else if (sfr_addr == P6_ANALOG_SEL_ADDR) begin
        nxt_rdata = p6_analog_ff & P6_IMPL_MASK; // R14
      end else if (sfr_addr == P6_OUT_DRIVE_ADDR) begin
        nxt_rdata = p6_drive_ff & P6_IMPL_MASK; // R14
      end else begin
        nxt_rdata = SFR_READ_IDLE;
      end
    end
  end

  // Reset, too, waits for the clock enable
  always_ff @(posedge clk) begin
    if (ce) begin
      if (rst) begin
        p3_analog_ff <= P3_ANALOG_SEL_RST;
        p3_drive_ff <= P3_OUT_DRIVE_RST;
        p6_analog_ff <= P6_ANALOG_SEL_RST;
        p6_drive_ff <= P6_OUT_DRIVE_RST;
      end else begin
        p3_analog_ff <= nxt_p3_analog;
        p3_drive_ff <= nxt_p3_drive;
        p6_analog_ff <= nxt_p6_analog;
        p6_drive_ff <= nxt_p6_drive;
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk) begin
    if (ce) begin
      if (rst) begin
        rdata_ff <= SFR_READ_IDLE;
      end else begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign sfr_rdata = rdata_ff;

  // Pin input synchroniser
  logic [ALL_PINS-1:0] sync1_ff, nxt_sync1;
  logic [ALL_PINS-1:0] sync2_ff, nxt_sync2;

  // Two stages before any logic reads a pad
  always_comb begin
    nxt_sync1 = pin_in;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (rst) begin
        sync1_ff <= '0;
        sync2_ff <= '0;
      end else begin
        sync1_ff <= nxt_sync1;
        sync2_ff <= nxt_sync2;
      end
    end
  end

  // Crossbar placement
  padc_xbar_if xb_if ();

  always_comb begin
    // Slave select only competes for a pin in four-wire mode
    xb_if.sig_enable = periph_enable;
    xb_if.sig_enable[SIG_SPI_SS] = periph_enable[SIG_SPI_SS] & spi_four_wire; // R8
    xb_if.pin_skip = port_pin_skip_bits; // R4 R7
  end

  padc_xbar u_xbar (
    .xb(xb_if.xbar)
  );

  // Value each crossbar-capable pin would drive
  logic [XBAR_PINS-1:0] xbar_value;

  always_comb begin
    for (int p = 0; p < XBAR_PINS; p++) begin
      if (xb_if.pin_sel[p] != SIG_CODE_NONE) begin
        // Input-only peripherals hold their output high, which releases the pin only in open-drain mode
        xbar_value[p] = periph_out[xb_if.pin_sel[p] - 5'h01];
      end else begin
        xbar_value[p] = port012_latch[p];
      end
    end
  end

  // Per-pin mode logic
  logic [XBAR_PINS-1:0] p012_out, p012_oe, p012_pu, p012_rx, p012_an;
  logic [P3_PINS-1:0] p3_out, p3_oe, p3_pu, p3_rx, p3_an;
  logic [P6_PINS-1:0] p6_out, p6_oe, p6_pu, p6_rx, p6_an;

  padc_pin_mode #(
    .W(XBAR_PINS)
  ) u_mode_p012 (
    .digital_sel(port012_analog_select), // R1 R9
    .push_pull(port012_output_drive_select),
    .value(xbar_value),
    .drive_out(p012_out),
    .drive_oe(p012_oe),
    .pullup_en(p012_pu),
    .receiver_en(p012_rx),
    .analog_en(p012_an)
  );

  padc_pin_mode #(
    .W(P3_PINS)
  ) u_mode_p3 (
    .digital_sel(p3_analog_ff), // R9
    .push_pull(p3_drive_ff),
    .value(port3_latch),
    .drive_out(p3_out),
    .drive_oe(p3_oe),
    .pullup_en(p3_pu),
    .receiver_en(p3_rx),
    .analog_en(p3_an)
  );

  padc_pin_mode #(
    .W(P6_PINS)
  ) u_mode_p6 (
    .digital_sel(p6_analog_ff[P6_PINS-1:0]), // R9
    .push_pull(p6_drive_ff[P6_PINS-1:0]),
    .value(port6_latch),
    .drive_out(p6_out),
    .drive_oe(p6_oe),
    .pullup_en(p6_pu),
    .receiver_en(p6_rx),
    .analog_en(p6_an)
  );

  // Registered pin controls
  logic [ALL_PINS-1:0] out_ff, nxt_out;
  logic [ALL_PINS-1:0] oe_ff, nxt_oe;
  logic [ALL_PINS-1:0] pu_ff, nxt_pu;
  logic [ALL_PINS-1:0] rx_ff, nxt_rx;
  logic [ALL_PINS-1:0] an_ff, nxt_an;
  logic [ALL_PINS-1:0] val_ff, nxt_val;

  always_comb begin
    nxt_out = {p6_out, p3_out, p012_out};
    nxt_oe = {p6_oe, p3_oe, p012_oe};
    nxt_pu = {p6_pu, p3_pu, p012_pu};
    nxt_rx = {p6_rx, p3_rx, p012_rx};
    nxt_an = {p6_an, p3_an, p012_an};
    // A disabled receiver reads low
    nxt_val = sync2_ff & {p6_rx, p3_rx, p012_rx}; // R11
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (rst) begin
        out_ff <= '0;
        oe_ff <= '0;
        pu_ff <= '0;
        rx_ff <= '0;
        an_ff <= '0;
        val_ff <= '0;
      end else begin
        out_ff <= nxt_out;
        oe_ff <= nxt_oe;
        pu_ff <= nxt_pu;
        rx_ff <= nxt_rx;
        an_ff <= nxt_an;
        val_ff <= nxt_val;
      end
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign pin_pullup_en = pu_ff;
  assign pin_receiver_en = rx_ff;
  assign pin_analog_en = an_ff;
  assign pin_value = val_ff;

  // Registered crossbar map and peripheral inputs
  logic [XBAR_PINS-1:0][SIG_CODE_W-1:0] assign_ff, nxt_assign;
  logic [N_SIG-1:0] placed_ff, nxt_placed;
  logic [N_SIG-1:0] pin_in_ff, nxt_pin_in;

  always_comb begin
    for (int p = 0; p < XBAR_PINS; p++) begin
      nxt_assign[p] = xb_if.pin_sel[p];
    end
    nxt_placed = xb_if.sig_placed;
    for (int s = 0; s < N_SIG; s++) begin
      if (xb_if.sig_placed[s]) begin
        nxt_pin_in[s] = sync2_ff[xb_if.sig_pin[s]] & port012_analog_select[xb_if.sig_pin[s]]; // R11
      end else begin
        // Unplaced inputs idle high
        nxt_pin_in[s] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (rst) begin
        assign_ff <= '0;
        placed_ff <= '0;
        pin_in_ff <= '1;
      end else begin
        assign_ff <= nxt_assign;
        placed_ff <= nxt_placed;
        pin_in_ff <= nxt_pin_in;
      end
    end
  end

  assign pin_assign = assign_ff;
  assign periph_placed = placed_ff;
  assign periph_in = pin_in_ff;
endmodule // padc_top

// ---- hw/padc_pkg.sv ----
package padc_pkg;
  // Register map, configuration page
  localparam logic [3:0] SFR_PAGE_CFG = 4'hF;
  localparam logic [7:0] P6_OUT_DRIVE_ADDR = 8'h9C;
  localparam logic [7:0] P3_OUT_DRIVE_ADDR = 8'hAF;
  localparam logic [7:0] P3_ANALOG_SEL_ADDR = 8'hF4;
  localparam logic [7:0] P6_ANALOG_SEL_ADDR = 8'hF7;

  // Reset values and implemented bits
  localparam logic [7:0] P3_OUT_DRIVE_RST = 8'h00;
  localparam logic [7:0] P3_ANALOG_SEL_RST = 8'hFF;
  localparam logic [7:0] P6_OUT_DRIVE_RST = 8'h00;
  localparam logic [7:0] P6_ANALOG_SEL_RST = 8'h3F;
  localparam logic [7:0] P6_IMPL_MASK = 8'h3F;
  localparam logic [7:0] SFR_READ_IDLE = 8'h00;

  // Pin counts
  localparam int XBAR_PINS = 24;
  localparam int P3_PINS = 8;
  localparam int P6_PINS = 6;
  localparam int ALL_PINS = 38;
  localparam int P3_BASE = 24;
  localparam int P6_BASE = 32;

  // Crossbar signals, highest priority first; code = index + 1, code 0 = none
  localparam int N_SIG = 18;
  localparam int SIG_UART_TX = 0;
  localparam int SIG_UART_RX = 1;
  localparam int SIG_SPI_SCK = 2;
  localparam int SIG_SPI_MISO = 3;
  localparam int SIG_SPI_MOSI = 4;
  localparam int SIG_SPI_SS = 5;
  localparam int SIG_SMB_SDA = 6;
  localparam int SIG_SMB_SCL = 7;
  localparam int SIG_CMP_SYNC = 8;
  localparam int SIG_CMP_ASYNC = 9;
  localparam int SIG_SYSCLK = 10;
  localparam int SIG_CAPTURE_COMPARE_IO_ZERO = 11;
  localparam int SIG_CAPTURE_COMPARE_IO_ONE = 12;
  localparam int SIG_CAPTURE_COMPARE_IO_TWO = 13;
  localparam int SIG_ECI = 14;
  localparam int SIG_T0 = 15;
  localparam int SIG_T1 = 16;
  localparam int SIG_SPARE = 17;
  localparam int SIG_CODE_W = 5;
  localparam int PIN_IDX_W = 5;
  localparam logic [SIG_CODE_W-1:0] SIG_CODE_NONE = 5'h00;

  typedef logic [SIG_CODE_W-1:0] padc_code_t;
  typedef logic [PIN_IDX_W-1:0] padc_pin_t;
endpackage

// ---- hw/padc_xbar_if.sv ----
`timescale 1ns/100ps
interface padc_xbar_if;
  import padc_pkg::*;
  logic [N_SIG-1:0] sig_enable;
  logic [XBAR_PINS-1:0] pin_skip;
  padc_code_t pin_sel [XBAR_PINS];
  padc_pin_t sig_pin [N_SIG];
  logic [N_SIG-1:0] sig_placed;

  modport xbar (
    input sig_enable,
    input pin_skip,
    output pin_sel,
    output sig_pin,
    output sig_placed
  );
  modport user (
    output sig_enable,
    output pin_skip,
    input pin_sel,
    input sig_pin,
    input sig_placed
  );
endinterface // padc_xbar_if

// ---- hw/padc_pin_mode.sv ----
`timescale 1ns/100ps
module padc_pin_mode #(
  parameter int W = 8
) (
  input wire logic [W-1:0] digital_sel,
  input wire logic [W-1:0] push_pull,
  input wire logic [W-1:0] value,
  output logic [W-1:0] drive_out,
  output logic [W-1:0] drive_oe,
  output logic [W-1:0] pullup_en,
  output logic [W-1:0] receiver_en,
  output logic [W-1:0] analog_en
);
  always_comb begin
    analog_en = ~digital_sel; // R10
    pullup_en = digital_sel; // R11
    receiver_en = digital_sel; // R11
    // Open-drain never drives a high level, even with the driver off
    drive_out = value & digital_sel & push_pull; // R12 R13
    // Open-drain only pulls low; push-pull drives both levels
    drive_oe = digital_sel & (push_pull | ~value); // R11 R12 R13
  end
endmodule // padc_pin_mode

// ---- hw/padc_xbar.sv ----
`timescale 1ns/100ps
module padc_xbar
  import padc_pkg::*;
(
  padc_xbar_if.xbar xb
);
  logic [XBAR_PINS-1:0] taken;
  logic found;

  always_comb begin
    taken = '0;
    found = 1'b0;
    for (int p = 0; p < XBAR_PINS; p++) begin
      xb.pin_sel[p] = SIG_CODE_NONE;
    end
    // Priority order is the signal index order
    for (int s = 0; s < N_SIG; s++) begin // R5
      xb.sig_pin[s] = '0;
      xb.sig_placed[s] = 1'b0;
      found = 1'b0;
      if (xb.sig_enable[s]) begin
        for (int p = 0; p < XBAR_PINS; p++) begin // R6
          if (!found && !xb.pin_skip[p] && !taken[p]) begin // R4
            taken[p] = 1'b1;
            found = 1'b1;
            xb.pin_sel[p] = padc_code_t'(s + 1);
            xb.sig_pin[s] = padc_pin_t'(p);
            xb.sig_placed[s] = 1'b1;
          end
        end
      end
    end
  end
endmodule // padc_xbar

// ---- dv/padc_pad_model.sv ----
`timescale 1ns/100ps
module padc_pad_model
  import padc_pkg::*;
(
  input wire logic clk,
  input wire logic [ALL_PINS-1:0] pin_out,
  input wire logic [ALL_PINS-1:0] pin_oe,
  input wire logic [ALL_PINS-1:0] pin_pullup_en,
  input wire logic [ALL_PINS-1:0] ext_level,
  input wire logic [ALL_PINS-1:0] ext_en,
  output logic [ALL_PINS-1:0] pin_in
);
  logic [ALL_PINS-1:0] float_ff = '0;
  // Pads with no driver and no pull-up wander instead of holding a level
  always_ff @(posedge clk) float_ff <= ~float_ff;
  always_comb begin
    for (int i = 0; i < ALL_PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_level[i];
      else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_ff[i];
    end
  end
endmodule // padc_pad_model

// ---- dv/padc_top_chk.sv ----
`timescale 1ns/100ps
module padc_top_chk
  import padc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_rdata,
  input wire logic [XBAR_PINS-1:0] port012_analog_select,
  input wire logic [XBAR_PINS-1:0] port012_output_drive_select,
  input wire logic [XBAR_PINS-1:0] port_pin_skip_bits,
  input wire logic [N_SIG-1:0] periph_enable,
  input wire logic spi_four_wire,
  input wire logic [ALL_PINS-1:0] pin_out,
  input wire logic [ALL_PINS-1:0] pin_oe,
  input wire logic [ALL_PINS-1:0] pin_pullup_en,
  input wire logic [ALL_PINS-1:0] pin_receiver_en,
  input wire logic [ALL_PINS-1:0] pin_analog_en,
  input wire logic [XBAR_PINS-1:0][SIG_CODE_W-1:0] pin_assign,
  input wire logic [N_SIG-1:0] periph_placed
);
  logic [XBAR_PINS-1:0] taken, pp_mask, od_mask;
  always_comb begin
    for (int i = 0; i < XBAR_PINS; i++) begin
      taken[i] = |pin_assign[i];
    end
    pp_mask = port012_analog_select & port012_output_drive_select;
    od_mask = port012_analog_select & ~port012_output_drive_select;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_p6;
    ce && sfr_rd_en && sfr_page == SFR_PAGE_CFG && sfr_addr == P6_ANALOG_SEL_ADDR;
  endsequence
  analog_quiet_a: assert property ((pin_analog_en & (pin_oe | pin_pullup_en | pin_receiver_en)) == '0)
    else $error("analog pin has a digital path on");
  skip_kept_a: assert property (ce |=> (taken & $past(port_pin_skip_bits)) == '0)
    else $error("skipped pin got a signal");
  nss_gate_a: assert property (ce && !spi_four_wire |=> !periph_placed[SIG_SPI_SS])
    else $error("slave select placed in three wire mode");
  analog_map_a: assert property (ce |=> pin_analog_en[XBAR_PINS-1:0] == ~$past(port012_analog_select))
    else $error("analog enable does not follow select");
  push_pull_a: assert property (ce |=> (pin_oe[XBAR_PINS-1:0] & $past(pp_mask)) == $past(pp_mask))
    else $error("push-pull pin not driven");
  open_drain_a: assert property (ce |=> (pin_out[XBAR_PINS-1:0] & $past(od_mask)) == '0)
    else $error("open-drain pin drives high");
  drive_ignored_a: assert property (ce |=> (pin_out[XBAR_PINS-1:0] & ~$past(port012_analog_select)) == '0)
    else $error("analog pin follows drive mode");
  p6_unused_a: assert property (rd_p6 |=> sfr_rdata[7:6] == 2'h0)
    else $error("unused bits read nonzero");
  top_prio_a: assert property (ce && periph_enable[SIG_UART_TX] && !port_pin_skip_bits[0] |=> pin_assign[0] == 5'h01)
    else $error("first signal not on first pin");
endmodule // padc_top_chk
bind padc_top padc_top_chk i_chk (
  .clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_rd_en(sfr_rd_en),
  .sfr_rdata(sfr_rdata), .port012_analog_select(port012_analog_select),
  .port012_output_drive_select(port012_output_drive_select), .port_pin_skip_bits(port_pin_skip_bits),
  .periph_enable(periph_enable), .spi_four_wire(spi_four_wire), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .pin_receiver_en(pin_receiver_en), .pin_analog_en(pin_analog_en),
  .pin_assign(pin_assign), .periph_placed(periph_placed)
);

// ---- dv/padc_top_bench.sv ----
`timescale 1ns/100ps
module padc_top_bench
  import padc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0, spi_four_wire = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [3:0] sfr_page = 4'h0;
  logic [XBAR_PINS-1:0] port012_analog_select = '1, port012_output_drive_select = '0, port_pin_skip_bits = '0;
  logic [XBAR_PINS-1:0] port012_latch = '0;
  logic [N_SIG-1:0] periph_enable = '0, periph_out = '1, periph_placed, periph_in, eplc;
  logic [P3_PINS-1:0] port3_latch = '0;
  logic [P6_PINS-1:0] port6_latch = '0;
  logic [ALL_PINS-1:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_receiver_en, pin_analog_en, pin_value;
  logic [ALL_PINS-1:0] ext_level = '0, ext_en = '0;
  logic [XBAR_PINS-1:0][SIG_CODE_W-1:0] pin_assign, easg;
  logic [XBAR_PINS-1:0] eo, eoe;
  logic [ALL_PINS-1:0] emask;
  logic [N_SIG-1:0] ein;
  logic [31:0] seed = 32'h9D3F6909;
  int errors = 0, samples_checked = 0;
  logic [7:0] addr_tbl [4] = '{P3_ANALOG_SEL_ADDR, P3_OUT_DRIVE_ADDR, P6_ANALOG_SEL_ADDR, P6_OUT_DRIVE_ADDR};
  logic [7:0] rst_tbl [4] = '{P3_ANALOG_SEL_RST, P3_OUT_DRIVE_RST, P6_ANALOG_SEL_RST, P6_OUT_DRIVE_RST};

  padc_top i_dut (
    .clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .port012_analog_select(port012_analog_select), .port012_output_drive_select(port012_output_drive_select),
    .port_pin_skip_bits(port_pin_skip_bits), .periph_enable(periph_enable), .spi_four_wire(spi_four_wire),
    .periph_out(periph_out), .port012_latch(port012_latch), .port3_latch(port3_latch), .port6_latch(port6_latch),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_receiver_en(pin_receiver_en), .pin_analog_en(pin_analog_en), .pin_value(pin_value),
    .pin_assign(pin_assign), .periph_placed(periph_placed), .periph_in(periph_in)
  );
  padc_pad_model i_pads (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .ext_level(ext_level),
    .ext_en(ext_en), .pin_in(pin_in)
  );

  initial forever #25 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Reference placement: signals in index order take the lowest free pin
  function automatic void xbar_ref(input logic [N_SIG-1:0] en, input logic [XBAR_PINS-1:0] skip, input logic fw,
                                   output logic [XBAR_PINS-1:0][SIG_CODE_W-1:0] asg, output logic [N_SIG-1:0] plc);
    logic [XBAR_PINS-1:0] used;
    used = skip;
    asg = '0;
    plc = '0;
    for (int s = 0; s < N_SIG; s++) begin
      for (int p = 0; p < XBAR_PINS; p++) begin
        if (en[s] && (s != SIG_SPI_SS || fw) && !used[p] && !plc[s]) begin
          used[p] = 1'b1;
          plc[s] = 1'b1;
          asg[p] = SIG_CODE_W'(s + 1);
        end
      end
    end
  endfunction

  // Reference drive: push-pull shows the value, open-drain only pulls low, analog is off
  function automatic void drive_ref(input logic [XBAR_PINS-1:0][SIG_CODE_W-1:0] asg, input logic [N_SIG-1:0] po,
                                    input logic [XBAR_PINS-1:0] lat, dig, pp,
                                    output logic [XBAR_PINS-1:0] o, output logic [XBAR_PINS-1:0] oe);
    logic v;
    for (int p = 0; p < XBAR_PINS; p++) begin
      v = (asg[p] != 5'h00) ? po[asg[p] - 5'h01] : lat[p];
      o[p] = v & dig[p] & pp[p];
      oe[p] = dig[p] & (pp[p] | ~v);
    end
  endfunction

  task automatic check(input string what, input logic [119:0] seen, input logic [119:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic sfr_wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr_page = pg;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr_en = 1'b1;
    @(negedge clk);
    sfr_wr_en = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_page = SFR_PAGE_CFG;
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    @(negedge clk);
    sfr_rd_en = 1'b0;
    check("register read", 120'(sfr_rdata), 120'(e));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(3000 * 50);
    errors++;
    conclude();
  end

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(addr_tbl[i], rst_tbl[i]);
    sfr_wr(SFR_PAGE_CFG, P6_ANALOG_SEL_ADDR, 8'hC0);
    rd_chk(P6_ANALOG_SEL_ADDR, 8'h00);
    sfr_wr(SFR_PAGE_CFG, P6_OUT_DRIVE_ADDR, 8'hFF);
    rd_chk(P6_OUT_DRIVE_ADDR, 8'h3F);
    sfr_wr(4'h0, P3_ANALOG_SEL_ADDR, 8'h00);
    rd_chk(P3_ANALOG_SEL_ADDR, 8'hFF);
    rd_chk(8'h00, 8'h00);
    $display("register test done");
    seed = xs(seed);
    d = seed[7:0];
    sfr_wr(SFR_PAGE_CFG, P3_ANALOG_SEL_ADDR, d);
    sfr_wr(SFR_PAGE_CFG, P3_OUT_DRIVE_ADDR, 8'hFF);
    port3_latch = seed[15:8];
    repeat (5) @(negedge clk);
    check("port3 analog", 120'(pin_analog_en[31:24]), 120'(d ^ 8'hFF));
    check("port3 oe", 120'(pin_oe[31:24]), 120'(d));
    check("port3 pad", 120'(pin_value[31:24] & d), 120'(seed[15:8] & d));
    sfr_wr(SFR_PAGE_CFG, P3_ANALOG_SEL_ADDR, 8'hFF);
    sfr_wr(SFR_PAGE_CFG, P3_OUT_DRIVE_ADDR, 8'h00);
    repeat (2) @(negedge clk);
    check("port3 open drain oe", 120'(pin_oe[31:24]), 120'(port3_latch ^ 8'hFF));
    check("port3 open drain out", 120'(pin_out[31:24]), 120'(8'h00));
    $display("pin mode test done");
    for (int n = 0; n < 60; n++) begin
      seed = xs(seed);
      periph_enable = (n == 0) ? 18'h1FFFF : (N_SIG'(seed) & 18'h1FFFF);
      port012_analog_select = 24'(xs(seed + 2));
      port_pin_skip_bits = (n == 1) ? 24'hFFFFFF : 24'(xs(seed) & xs(seed + 1)) | ~port012_analog_select;
      spi_four_wire = seed[31];
      port012_output_drive_select = 24'(xs(seed + 3));
      port012_latch = 24'(xs(seed + 4));
      periph_out = N_SIG'(xs(seed + 5));
      ext_level = ALL_PINS'({xs(seed + 6), xs(seed + 7)});
      ext_en = ALL_PINS'({xs(seed + 8), xs(seed + 9)}) & ~pin_oe;
      @(negedge clk);
      xbar_ref(periph_enable, port_pin_skip_bits, spi_four_wire, easg, eplc);
      check("pin assignment", 120'(pin_assign), 120'(easg));
      check("signals placed", 120'(periph_placed), 120'(eplc));
      drive_ref(easg, periph_out, port012_latch, port012_analog_select, port012_output_drive_select, eo, eoe);
      check("crossbar pin out", 120'(pin_out[XBAR_PINS-1:0]), 120'(eo));
      check("crossbar pin oe", 120'(pin_oe[XBAR_PINS-1:0]), 120'(eoe));
    end
    ext_en = '1;
    repeat (5) @(negedge clk);
    emask = {6'h00, 8'hFF, port012_analog_select};
    ein = '1;
    for (int p = 0; p < XBAR_PINS; p++) begin
      if (easg[p] != 5'h00) begin
        ein[easg[p] - 5'h01] = pin_in[p] & port012_analog_select[p];
      end
    end
    check("pad levels", 120'(pin_value), 120'(pin_in & emask));
    check("pull-ups", 120'(pin_pullup_en), 120'(emask));
    check("receivers", 120'(pin_receiver_en), 120'(emask));
    check("analog pins", 120'(pin_analog_en), 120'(emask ^ {ALL_PINS{1'b1}}));
    check("peripheral inputs", 120'(periph_in), 120'(ein));
    $display("crossbar test done");
    ce = 1'b0;
    port012_analog_select = port012_analog_select ^ 24'hFFFFFF;
    repeat (2) @(negedge clk);
    check("frozen analog pins", 120'(pin_analog_en), 120'(emask ^ {ALL_PINS{1'b1}}));
    ce = 1'b1;
    @(negedge clk);
    check("thawed analog pins", 120'(pin_analog_en[XBAR_PINS-1:0]), 120'(port012_analog_select ^ 24'hFFFFFF));
    $display("clock enable test done");
    conclude();
  end
endmodule // padc_top_bench
